/* design/sfsk_tx_defines.vh */
// Constants for the transmit level and strap control block
// Assumes a 100 MHz clock and byte addresses on the register port
`ifndef SFSK_TX_DEFINES_VH
`define SFSK_TX_DEFINES_VH

// ****************************************
// Clock and bit timing
// ****************************************
`define CLK_HZ 100000000
`define BAUD_50_BASE 300
`define BAUD_60_BASE 360
`define QTRS_PER_BIT 4
`define CNT_W 24

// ****************************************
// Frame and level control
// ****************************************
`define FRAME_LAST_BIT 9'h11f
`define FRAME_WORDS 9
`define ADAPT_BITS 9'h002
`define ADAPT_LAST 3'h7
`define GAIN_MAX 3'h7
`define GAIN_MIN 3'h0
`define STRAP_WAIT 3'h5
`define STRAP_LAST 3'h4

// ****************************************
// Carrier programming in 10 Hz steps
// ****************************************
`define CARRIER_MIN 14'h0384
`define CARRIER_MAX 14'h251c
`define SPACE_RESET 14'h0384
`define MARK_RESET 14'h0bb8

// ****************************************
// Register map
// ****************************************
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_GAIN 8'h08
`define ADDR_SPACE 8'h0c
`define ADDR_MARK 8'h10
`define ADDR_FRAMES 8'h14
`define DATA_PAGE 2'h1

// CTRL fields
`define CTRL_START 0
`define CTRL_ABORT 1
`define CTRL_SOFT_RST 2
`define CTRL_MAINS60 3
`define CTRL_RATE_LO 4
`define CTRL_RATE_HI 5
`define CTRL_TEST_TONE 6

// STATUS fields
`define ST_HOST_REQ 1

// Synchronised pin positions
`define PIN_RESET 0
`define PIN_TEST 1
`define PIN_STRAP_LO 2
`define PIN_STRAP_HI 3
`define PIN_REQ 4
`define PIN_BELOW 5
`define PIN_ABOVE 6
`define PIN_TONE 7
`define PIN_DRV 8
`define PIN_COUNT 9
`define PIN_INIT 9'h011

`endif

/* design/input_sync.v */
// Three-stage synchroniser with agreement filter for pin inputs
// Assumes asynchronous pins and one clock domain
`timescale 1ns/1ns
module input_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Pins and filtered levels
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] level_ff
);
  reg [WIDTH-1:0] stage1_ff;
  reg [WIDTH-1:0] stage2_ff;
  reg [WIDTH-1:0] stage3_ff;
  wire [WIDTH-1:0] nxt_level;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1_ff <= INIT;
      stage2_ff <= INIT;
      stage3_ff <= INIT;
      level_ff <= INIT;
    end else begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      level_ff <= nxt_level;
    end
  end

  // ****************************************
  // A change counts once stages two and three agree
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_filter
      assign nxt_level[i] = (stage2_ff[i] == stage3_ff[i]) ? stage3_ff[i] : level_ff[i];
    end
  endgenerate
endmodule // input_sync

/* design/level_adapter.v */
// Transmit gain stepping during the first bits of a frame
// Assumes synchronised comparator levels and one-cycle ticks
`timescale 1ns/1ns
`include "sfsk_tx_defines.vh"
module level_adapter (
  // Clock and reset
  input wire clock,
  input wire rst,
  input wire clear,
  // Frame timing
  input wire frame_start,
  input wire adapt_tick,
  // Comparator levels
  input wire below_low,
  input wire above_high,
  // Gain state
  output reg [2:0] gain_ff,
  output reg adapting_ff
);
  reg [2:0] step_cnt_ff;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      gain_ff <= `GAIN_MIN;
      adapting_ff <= 1'b0;
      step_cnt_ff <= 3'h0;
    end else if (clear) begin
      gain_ff <= `GAIN_MIN;
      adapting_ff <= 1'b0;
      step_cnt_ff <= 3'h0;
    end else if (frame_start) begin
      adapting_ff <= 1'b1;
      step_cnt_ff <= 3'h0;
    end else if (adapt_tick && adapting_ff) begin
      if (below_low && gain_ff != `GAIN_MAX) begin
        gain_ff <= gain_ff + 3'h1;
      end else if (above_high && gain_ff != `GAIN_MIN) begin
        gain_ff <= gain_ff - 3'h1;
      end
      step_cnt_ff <= step_cnt_ff + 3'h1;
      if (step_cnt_ff == `ADAPT_LAST) begin
        adapting_ff <= 1'b0;
      end
    end
  end
endmodule // level_adapter

/* design/sfsk_tx_level_and_strap_control.v */
// Transmit tone bit, line driver enable, level control and rate straps
// Assumes a 100 MHz clock, asynchronous pins and a one-cycle register port
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`include "sfsk_tx_defines.vh"
module sfsk_tx_level_and_strap_control #(
  parameter QTR_CYC_50 = `CLK_HZ / (`BAUD_50_BASE * `QTRS_PER_BIT),
  parameter QTR_CYC_60 = `CLK_HZ / (`BAUD_60_BASE * `QTRS_PER_BIT)
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Register port
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata_ff,
  // Reset, test and strap pins
  input wire hw_reset_low,
  input wire test_enable,
  input wire rate_strap_low,
  input wire rate_strap_high,
  // Host request pin
  input wire host_req_low,
  // Level comparator pins
  input wire level_sense_below,
  input wire level_sense_above,
  // Tone bit pin, open drain
  input wire tone_bit_in,
  output reg tone_bit_out_ff,
  output reg tone_bit_oe_ff,
  // Line driver enable pin, open drain
  input wire line_driver_on_in,
  output reg line_driver_on_out_ff,
  output reg line_driver_on_oe_ff,
  // Transmit settings
  output wire [2:0] tx_gain,
  output reg [13:0] space_tone_step_ff,
  output reg [13:0] mark_tone_step_ff,
  output reg [1:0] host_serial_rate_ff,
  output reg test_mode_ff
);

  // ****************************************
  // Decoding
  // ****************************************
  function is_data;
    input [7:0] a;
    begin
      is_data = (a[7:6] == `DATA_PAGE) && (a[5:2] < `FRAME_WORDS) && (a[1:0] == 2'h0);
    end
  endfunction

  function [13:0] clamp_carrier;
    input [31:0] v;
    begin
      if (v[31:14] != 18'h0 || v[13:0] > `CARRIER_MAX) begin
        clamp_carrier = `CARRIER_MAX;
      end else if (v[13:0] < `CARRIER_MIN) begin
        clamp_carrier = `CARRIER_MIN;
      end else begin
        clamp_carrier = v[13:0];
      end
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [`PIN_COUNT-1:0] pins_s;

  input_sync #(
    .WIDTH(`PIN_COUNT),
    .INIT(`PIN_INIT)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .pin_in({line_driver_on_in, tone_bit_in, level_sense_above, level_sense_below, host_req_low,
      rate_strap_high, rate_strap_low, test_enable, hw_reset_low}),
    .level_ff(pins_s)
  );

  wire hw_rst_act = ~pins_s[`PIN_RESET];

  // ****************************************
  // Register state
  // ****************************************
  reg mains60_ff;
  reg [1:0] rate_ff;
  reg test_tone_ff;
  reg soft_rst_ff;
  reg host_req_ff;
  reg [2:0] strap_wait_ff;
  reg [31:0] frame_mem [0:`FRAME_WORDS-1];
  reg busy_ff;
  reg [8:0] bit_idx_ff;
  reg [1:0] qtr_ff;
  reg [`CNT_W-1:0] qcnt_ff;
  reg [15:0] frames_sent_ff;
  reg [15:0] frames_aborted_ff;
  wire adapting;

  wire clr = hw_rst_act | soft_rst_ff;
  wire ctrl_wr = wr && (addr == `ADDR_CTRL);
  wire start_req = ctrl_wr && wdata[`CTRL_START] && !busy_ff && !test_mode_ff;
  wire abort_req = busy_ff && (clr || test_mode_ff || (ctrl_wr && wdata[`CTRL_ABORT]));

  // Quarter-bit length from mains and rate selection
  wire [`CNT_W-1:0] base_len = mains60_ff ? QTR_CYC_60[`CNT_W-1:0] : QTR_CYC_50[`CNT_W-1:0];
  wire [1:0] rate_shift = (rate_ff == 2'h3) ? 2'h2 : rate_ff;
  wire [`CNT_W-1:0] qtr_len = base_len >> rate_shift;
  wire qtick = busy_ff && (qcnt_ff == qtr_len - {{(`CNT_W-1){1'b0}}, 1'b1});
  wire bit_end = qtick && (qtr_ff == 2'h3);
  wire frame_end = bit_end && (bit_idx_ff == `FRAME_LAST_BIT);
  wire adapt_tick = qtick && (bit_idx_ff < `ADAPT_BITS);
  wire [31:0] cur_word = frame_mem[bit_idx_ff[8:5]];
  wire cur_bit = cur_word[bit_idx_ff[4:0]];

  // ****************************************
  // Control registers
  // ****************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mains60_ff <= 1'b0;
      rate_ff <= 2'h0;
      test_tone_ff <= 1'b0;
      soft_rst_ff <= 1'b0;
      space_tone_step_ff <= `SPACE_RESET;
      mark_tone_step_ff <= `MARK_RESET;
    end else if (hw_rst_act) begin
      mains60_ff <= 1'b0;
      rate_ff <= 2'h0;
      test_tone_ff <= 1'b0;
      soft_rst_ff <= 1'b0;
      space_tone_step_ff <= `SPACE_RESET;
      mark_tone_step_ff <= `MARK_RESET;
    end else begin
      soft_rst_ff <= ctrl_wr && wdata[`CTRL_SOFT_RST];
      if (ctrl_wr) begin
        test_tone_ff <= wdata[`CTRL_TEST_TONE];
        if (!busy_ff) begin
          mains60_ff <= wdata[`CTRL_MAINS60];
          rate_ff <= wdata[`CTRL_RATE_HI:`CTRL_RATE_LO];
        end
      end
      if (wr && addr == `ADDR_SPACE) begin
        space_tone_step_ff <= clamp_carrier(wdata);
      end
      if (wr && addr == `ADDR_MARK) begin
        mark_tone_step_ff <= clamp_carrier(wdata);
      end
    end
  end

  // ****************************************
  // Frame data words
  // ****************************************
  always @(posedge clock) begin
    if (wr && is_data(addr) && !busy_ff) begin
      frame_mem[addr[5:2]] <= wdata;
    end
  end

  // ****************************************
  // Host request and test mode
  // ****************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      host_req_ff <= 1'b0;
      test_mode_ff <= 1'b0;
    end else if (hw_rst_act) begin
      host_req_ff <= 1'b0;
      test_mode_ff <= 1'b0;
    end else begin
      test_mode_ff <= pins_s[`PIN_TEST];
      if (!pins_s[`PIN_REQ]) begin
        host_req_ff <= 1'b1;
      end else if (wr && addr == `ADDR_STATUS && wdata[`ST_HOST_REQ]) begin
        host_req_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Rate strap capture after reset
  // ****************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_wait_ff <= 3'h0;
      host_serial_rate_ff <= 2'h0;
    end else if (clr) begin
      strap_wait_ff <= 3'h0;
    end else if (strap_wait_ff != `STRAP_WAIT) begin
      strap_wait_ff <= strap_wait_ff + 3'h1;
      if (strap_wait_ff == `STRAP_LAST) begin
        host_serial_rate_ff <= {pins_s[`PIN_STRAP_HI], pins_s[`PIN_STRAP_LO]};
      end
    end
  end

  // ****************************************
  // Frame engine
  // ****************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
      bit_idx_ff <= 9'h000;
      qtr_ff <= 2'h0;
      qcnt_ff <= {`CNT_W{1'b0}};
      frames_sent_ff <= 16'h0000;
      frames_aborted_ff <= 16'h0000;
    end else if (hw_rst_act) begin
      busy_ff <= 1'b0;
      bit_idx_ff <= 9'h000;
      qtr_ff <= 2'h0;
      qcnt_ff <= {`CNT_W{1'b0}};
      frames_sent_ff <= 16'h0000;
      frames_aborted_ff <= 16'h0000;
    end else begin
      if (start_req) begin
        busy_ff <= 1'b1;
        bit_idx_ff <= 9'h000;
        qtr_ff <= 2'h0;
        qcnt_ff <= {`CNT_W{1'b0}};
      end else if (abort_req) begin
        busy_ff <= 1'b0;
        frames_aborted_ff <= frames_aborted_ff + 16'h0001;
      end else if (busy_ff) begin
        if (qtick) begin
          qcnt_ff <= {`CNT_W{1'b0}};
          qtr_ff <= qtr_ff + 2'h1;
        end else begin
          qcnt_ff <= qcnt_ff + {{(`CNT_W-1){1'b0}}, 1'b1};
        end
        if (frame_end) begin
          busy_ff <= 1'b0;
          frames_sent_ff <= frames_sent_ff + 16'h0001;
        end else if (bit_end) begin
          bit_idx_ff <= bit_idx_ff + 9'h001;
        end
      end
    end
  end

  // ****************************************
  // Level controller
  // ****************************************
  level_adapter u_level (
    .clock(clock),
    .rst(rst),
    .clear(hw_rst_act),
    .frame_start(start_req),
    .adapt_tick(adapt_tick),
    .below_low(pins_s[`PIN_BELOW]),
    .above_high(pins_s[`PIN_ABOVE]),
    .gain_ff(tx_gain),
    .adapting_ff(adapting)
  );

  wire [4:0] gain_db = {1'b0, tx_gain, 1'b0} + {2'b00, tx_gain};

  // ****************************************
  // Open-drain pins
  // ****************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tone_bit_out_ff <= 1'b0;
      tone_bit_oe_ff <= 1'b0;
      line_driver_on_out_ff <= 1'b0;
      line_driver_on_oe_ff <= 1'b1;
    end else begin
      tone_bit_out_ff <= 1'b0;
      line_driver_on_out_ff <= 1'b0;
      if (test_mode_ff) begin
        tone_bit_oe_ff <= ~test_tone_ff;
      end else if (busy_ff) begin
        tone_bit_oe_ff <= ~cur_bit;
      end else begin
        tone_bit_oe_ff <= 1'b0;
      end
      line_driver_on_oe_ff <= ~(busy_ff | test_mode_ff);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  reg [31:0] rd_val;

  always @* begin
    rd_val = 32'h00000000;
    case (addr)
      `ADDR_CTRL: begin
        rd_val = {25'h0, test_tone_ff, rate_ff, mains60_ff, 3'h0};
      end
      `ADDR_STATUS: begin
        rd_val = {23'h0, ~pins_s[`PIN_REQ], adapting, host_serial_rate_ff, pins_s[`PIN_DRV],
          pins_s[`PIN_TONE], test_mode_ff, host_req_ff, busy_ff};
      end
      `ADDR_GAIN: begin
        rd_val = {19'h0, gain_db, 5'h0, tx_gain};
      end
      `ADDR_SPACE: begin
        rd_val = {18'h0, space_tone_step_ff};
      end
      `ADDR_MARK: begin
        rd_val = {18'h0, mark_tone_step_ff};
      end
      `ADDR_FRAMES: begin
        rd_val = {frames_aborted_ff, frames_sent_ff};
      end
      default: begin
        if (is_data(addr)) begin
          rd_val = frame_mem[addr[5:2]];
        end
      end
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= rd ? rd_val : 32'h00000000;
    end
  end

endmodule // sfsk_tx_level_and_strap_control

/* verification/line_partner.sv */
// Line driver side: pull-ups on the open-drain pins and the level comparators
// Assumes enables high while the block pulls a pin low
`timescale 1ns/1ns
module line_partner (
  // Open-drain enables and driven levels
  input wire tone_bit_oe,
  input wire line_driver_on_oe,
  input wire tone_bit_out,
  input wire line_driver_on_out,
  // Gain and wanted level
  input wire [2:0] tx_gain,
  input wire [2:0] target,
  // Pin and comparator levels
  output wire tone_pin,
  output wire drv_pin,
  output wire below,
  output wire above
);
  // ****************************************
  // Pull-ups and peak comparators
  // ****************************************
  assign tone_pin = tone_bit_oe ? tone_bit_out : 1'b1;
  assign drv_pin = line_driver_on_oe ? line_driver_on_out : 1'b1;
  assign below = tx_gain < target;
  assign above = tx_gain > target;
endmodule // line_partner

/* verification/sfsk_tx_sva.sv */
// Checker for the tone, driver, strap and gain ports
// Assumes it is bound to the top module of the block
`timescale 1ns/1ns
module sfsk_tx_sva #(
  parameter QTR_CYC_50 = 8,
  parameter QTR_CYC_60 = 6
) (
  // Clock, reset and register port
  input wire clock,
  input wire rst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  // Pins
  input wire hw_reset_low,
  input wire level_sense_below,
  input wire level_sense_above,
  // Outputs
  input wire tone_bit_out_ff,
  input wire tone_bit_oe_ff,
  input wire line_driver_on_oe_ff,
  input wire [2:0] tx_gain,
  input wire [1:0] host_serial_rate_ff,
  input wire test_mode_ff
);
  // ****************************************
  // Age counters and assertions
  // ****************************************
  localparam int SPAN = 8 * QTR_CYC_50 + 12;
  wire ctrl_wr = wr && addr == 8'h00;
  reg [7:0] rst_age_ff;
  reg [15:0] start_age_ff;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rst_age_ff <= 8'h00;
      start_age_ff <= 16'hffff;
    end else begin
      rst_age_ff <= (!hw_reset_low || (ctrl_wr && wdata[2])) ? 8'h00 : rst_age_ff + {7'h0, rst_age_ff != 8'hff};
      start_age_ff <= (ctrl_wr && wdata[0]) ? 16'h0000 : start_age_ff + {15'h0, start_age_ff != 16'hffff};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_tone_out_zero: assert property (tone_bit_out_ff == 1'b0)
    else $error("tone pin driven high");
  a_start_drives: assert property (ctrl_wr && wdata[2:0] == 3'h1 && line_driver_on_oe_ff && !test_mode_ff
    && rst_age_ff > 8'h10 |-> ##2 !line_driver_on_oe_ff) else $error("driver enable not raised on start");
  a_strap_hold: assert property ($changed(host_serial_rate_ff) |-> rst_age_ff < 8'h14)
    else $error("serial rate changed outside reset");
  a_hw_reset_clear: assert property ((!hw_reset_low)[*8] |-> tx_gain == 3'h0 && line_driver_on_oe_ff
    && !tone_bit_oe_ff) else $error("reset pin did not clear state");
  a_test_release: assert property (test_mode_ff[*3] |-> !line_driver_on_oe_ff)
    else $error("driver not released in test mode");
  a_gain_one_step: assert property ($changed(tx_gain) && rst_age_ff > 8'h10 |->
    ({1'b0, tx_gain} == {1'b0, $past(tx_gain)} + 4'h1) || ({1'b0, tx_gain} + 4'h1 == {1'b0, $past(tx_gain)}))
    else $error("gain moved more than one step");
  a_gain_no_rise: assert property ((!level_sense_below)[*8] ##0 rst_age_ff > 8'h10 |=> tx_gain <= $past(tx_gain))
    else $error("gain rose without low peak");
  a_gain_no_fall: assert property ((!level_sense_above)[*8] ##0 rst_age_ff > 8'h10 |=> tx_gain >= $past(tx_gain))
    else $error("gain fell without high peak");
  a_gain_window: assert property ($changed(tx_gain) && rst_age_ff > 8'h10 |-> start_age_ff < SPAN)
    else $error("gain moved outside frame head");
endmodule // sfsk_tx_sva

bind sfsk_tx_level_and_strap_control sfsk_tx_sva #(.QTR_CYC_50(QTR_CYC_50), .QTR_CYC_60(QTR_CYC_60)) sfsk_tx_sva_inst (
  .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .hw_reset_low(hw_reset_low),
  .level_sense_below(level_sense_below), .level_sense_above(level_sense_above), .tone_bit_out_ff(tone_bit_out_ff),
  .tone_bit_oe_ff(tone_bit_oe_ff), .line_driver_on_oe_ff(line_driver_on_oe_ff), .tx_gain(tx_gain),
  .host_serial_rate_ff(host_serial_rate_ff), .test_mode_ff(test_mode_ff));

/* verification/sfsk_tx_level_and_strap_control_bench.sv */
// Bench for the transmit level and strap control block
// Assumes the line partner model and quarter-bit counts of 8 and 6 cycles
`timescale 1ns/1ns
module sfsk_tx_level_and_strap_control_bench;
  // ****************************************
  // Signals, instances and tasks
  // ****************************************
  reg clock, rst, wr, rd, hw_reset_low, test_enable, strap_lo, strap_hi, host_req_low;
  reg [7:0] addr;
  reg [31:0] wdata, s;
  reg [2:0] target;
  wire [31:0] rdata_ff;
  wire [2:0] tx_gain;
  wire [13:0] space_step, mark_step;
  wire [1:0] rate;
  wire test_mode, tone_oe, drv_oe, tone_out, drv_out, tone_pin, drv_pin, below, above;
  integer fail_count, total_checks, k, r, sent;
  sfsk_tx_level_and_strap_control #(.QTR_CYC_50(8), .QTR_CYC_60(6)) sfsk_tx_level_and_strap_control_inst (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
    .hw_reset_low(hw_reset_low), .test_enable(test_enable), .rate_strap_low(strap_lo), .rate_strap_high(strap_hi),
    .host_req_low(host_req_low), .level_sense_below(below), .level_sense_above(above),
    .tone_bit_in(tone_pin), .tone_bit_out_ff(tone_out), .tone_bit_oe_ff(tone_oe),
    .line_driver_on_in(drv_pin), .line_driver_on_out_ff(drv_out), .line_driver_on_oe_ff(drv_oe),
    .tx_gain(tx_gain), .space_tone_step_ff(space_step), .mark_tone_step_ff(mark_step),
    .host_serial_rate_ff(rate), .test_mode_ff(test_mode));
  line_partner line_partner_inst (.tone_bit_oe(tone_oe), .line_driver_on_oe(drv_oe), .tone_bit_out(tone_out),
    .line_driver_on_out(drv_out), .tx_gain(tx_gain),
    .target(target), .tone_pin(tone_pin), .drv_pin(drv_pin), .below(below), .above(above));
  always #5 clock = ~clock;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t word %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_bit(input got, input exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t bit %b expected %b", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] v);
    begin
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a);
    begin
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 s = rdata_ff;
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp);
    begin
      rd_reg(a);
      chk(s, exp);
    end
  endtask
  task run_frame(input [31:0] cfg, input integer q, input [2:0] late);
    time t0;
    begin
      wr_reg(8'h00, cfg);
      wr_reg(8'h00, cfg | 32'h1);
      t0 = $time;
      repeat (2 * q) @(posedge clock);
      #1 chk_bit(tone_pin, 1'b0);
      chk_bit(drv_pin, 1'b1);
      repeat (4 * q) @(posedge clock);
      #1 chk_bit(tone_pin, 1'b1);
      repeat (4 * q) @(posedge clock);
      target <= late;
      s = 32'h1;
      while (s[0] && ($time - t0) < 200000) rd_reg(8'h04);
      chk_bit(($time - t0) / 10 >= 1152 * q && ($time - t0) / 10 <= 1152 * q + 8, 1'b1);
      chk_bit(drv_pin, 1'b0);
      sent = sent + 1;
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // ****************************************
  // Tests and watchdog
  // ****************************************
  initial begin
    #900000;
    fail_count = fail_count + 1;
    $display("BAD %0t watchdog expired", $time);
    print_verdict;
  end
  initial begin
    clock = 0; rst = 1; wr = 0; rd = 0; addr = 0; wdata = 0; hw_reset_low = 1; test_enable = 0;
    strap_hi = 1; strap_lo = 0; host_req_low = 1; target = 3'h7; fail_count = 0; total_checks = 0; sent = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (12) @(posedge clock);
    #1 chk(rate, 32'h2);
    {strap_hi, strap_lo} <= 2'b01;
    repeat (12) @(posedge clock);
    #1 chk(rate, 32'h2);
    wr_reg(8'h00, 32'h4);
    repeat (12) @(posedge clock);
    #1 chk(rate, 32'h1);
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h80, 32'h0);
    wr_reg(8'h0c, 32'h1);
    rd_chk(8'h0c, 32'h384);
    chk(space_step, 32'h384);
    wr_reg(8'h10, 32'hffff);
    rd_chk(8'h10, 32'h251c);
    wr_reg(8'h10, 32'h1388);
    rd_chk(8'h10, 32'h1388);
    chk(mark_step, 32'h1388);
    $display("register test done");
    for (k = 0; k < 9; k = k + 1) wr_reg(8'h40 + {k[5:0], 2'b00}, k == 0 ? 32'h2 : 32'h5a5a5a5a);
    rd_chk(8'h60, 32'h5a5a5a5a);
    run_frame(32'h0, 8, 3'h0);
    rd_chk(8'h08, 32'h1507);
    run_frame(32'h0, 8, 3'h4);
    rd_chk(8'h08, 32'h0000);
    run_frame(32'h0, 8, 3'h4);
    rd_chk(8'h08, 32'h0c04);
    for (k = 0; k < 8; k = k + 1) begin
      r = k % 4;
      run_frame({26'h0, r[1:0], k[2], 3'h0}, (k < 4 ? 8 : 6) >> (r == 3 ? 2 : r), 3'h4);
    end
    wr_reg(8'h00, 32'h1);
    repeat (20) @(posedge clock);
    wr_reg(8'h00, 32'h2);
    rd_reg(8'h04);
    chk_bit(s[0], 1'b0);
    rd_chk(8'h14, {16'h1, sent[15:0]});
    $display("frame test done");
    host_req_low <= 1'b0;
    repeat (8) @(posedge clock);
    rd_reg(8'h04);
    chk(s[8:1] & 8'h81, 32'h81);
    host_req_low <= 1'b1;
    repeat (8) @(posedge clock);
    rd_reg(8'h04);
    chk(s[8:1] & 8'h81, 32'h01);
    wr_reg(8'h04, 32'h2);
    rd_reg(8'h04);
    chk_bit(s[1], 1'b0);
    test_enable <= 1'b1;
    repeat (8) @(posedge clock);
    #1 chk_bit(test_mode, 1'b1);
    chk_bit(drv_pin, 1'b1);
    wr_reg(8'h00, 32'h40);
    rd_chk(8'h00, 32'h40);
    repeat (3) @(posedge clock);
    #1 chk_bit(tone_pin, 1'b1);
    wr_reg(8'h00, 32'h1);
    repeat (3) @(posedge clock);
    #1 chk_bit(tone_pin, 1'b0);
    rd_reg(8'h04);
    chk_bit(s[0], 1'b0);
    test_enable <= 1'b0;
    repeat (8) @(posedge clock);
    #1 chk_bit(test_mode, 1'b0);
    chk_bit(drv_pin, 1'b0);
    $display("pin test done");
    for (k = 0; k < 4; k = k + 1) begin
      {strap_hi, strap_lo} <= k[1:0];
      hw_reset_low <= 1'b0;
      repeat (8) @(posedge clock);
      #1 chk(tx_gain, 32'h0);
      hw_reset_low <= 1'b1;
      repeat (16) @(posedge clock);
      #1 chk(rate, k);
    end
    $display("strap test done");
    print_verdict;
  end
endmodule // sfsk_tx_level_and_strap_control_bench
